/* File: logic/status_pkg.sv */
/*
  Shared constants for the serial bus status flag block: register offsets,
  field positions and reset values.
  Assumes a 32-bit APB register bus, each register one aligned word.
*/
package status_pkg;
    // Register byte offsets.
    localparam logic [11:0] OFF_STATUS = 12'h000;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h004;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h008;
    localparam logic [11:0] OFF_TX_BUFFER = 12'h00c;
    localparam logic [11:0] OFF_RX_BUFFER = 12'h010;
    // Status word field positions.
    localparam int BIT_ACK_RESULT = 15;
    localparam int BIT_TX_PROGRESS = 14;
    localparam int BIT_BUS_COLL = 10;
    localparam int BIT_GEN_CALL = 9;
    localparam int BIT_TEN_BIT = 8;
    localparam int BIT_WR_COLL = 7;
    localparam int BIT_RX_OVF = 6;
    localparam int BIT_STOP_SEEN = 4;
    localparam int BIT_START_SEEN = 3;
    // Interrupt status field positions.
    localparam int IRQ_BUS_COLL = 0;
    localparam int IRQ_WR_COLL = 1;
    localparam int IRQ_RX_OVF = 2;
    localparam int IRQ_STOP = 3;
    localparam int IRQ_WIDTH = 4;
    // Reset values.
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [7:0] BUFFER_RESET = 8'h00;
endpackage

/* File: logic/sticky_irq.sv */
/*
  Sticky interrupt status with mask and write-one-to-clear.
  Assumes events are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
module sticky_irq #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Events and software access.
    input wire logic [WIDTH-1:0] event_pulse,
    input wire logic [WIDTH-1:0] clear_bits,
    input wire logic [WIDTH-1:0] mask_bits,
    // Results.
    output logic [WIDTH-1:0] status_bits,
    output logic irq
);
    // Refuse a width that leaves no status bit to hold.
    if (WIDTH < 1) begin : g_bad_width
        $error("sticky_irq needs WIDTH of at least one");
    end

    // A new event in the clearing cycle wins, so no event is lost.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_bits <= '0;
        end else begin
            status_bits <= (status_bits & ~clear_bits) | event_pulse;
        end
    end

    // Level output while any unmasked bit stands.
    assign irq = |(status_bits & mask_bits);
endmodule // sticky_irq

/* File: logic/serial_status_flags.sv */
/*
  Upper status flags of a two-wire serial bus controller, an APB slave for
  software access, and a sticky masked interrupt.
  Assumes the bus engine gives one-cycle event pulses on ref_clk.
*/
`timescale 1ns/1ps
module serial_status_flags (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bus engine events.
    input wire logic master_op_active,
    input wire logic engine_busy,
    input wire logic tx_start,
    input wire logic ack_end,
    input wire logic ack_nack,
    input wire logic collision_seen,
    input wire logic gen_call_match,
    input wire logic ten_bit_second_match,
    input wire logic start_seen,
    input wire logic stop_seen,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    // Engine side of the transmit buffer.
    output logic [7:0] tx_data,
    output logic tx_load,
    // Status outputs.
    output logic [15:0] serial_bus_status,
    output logic irq
);
    logic slave_ack_result_reg;
    logic master_tx_in_progress_reg;
    logic bus_collision_flag_reg;
    logic general_call_flag_reg;
    logic ten_bit_addr_matched_reg;
    logic tx_write_collision_reg;
    logic rx_overflow_flag_reg;
    logic stop_flag_reg;
    logic start_flag_reg;
    logic rx_full_reg;
    logic [7:0] rx_buffer_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] irq_status;
    logic [3:0] irq_clear;
    logic [3:0] irq_event;
    logic wr_access;
    logic rd_access;
    logic status_wr;
    logic tx_wr;
    logic rx_rd;
    logic addr_ok;
    logic [31:0] rdata_next;

    // Every access completes in its first access cycle, so pready is constant.
    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign status_wr = wr_access && (paddr == status_pkg::OFF_STATUS);
    assign tx_wr = wr_access && (paddr == status_pkg::OFF_TX_BUFFER);
    assign rx_rd = rd_access && (paddr == status_pkg::OFF_RX_BUFFER);
    assign addr_ok = (paddr == status_pkg::OFF_STATUS) ||
                     (paddr == status_pkg::OFF_IRQ_STATUS) ||
                     (paddr == status_pkg::OFF_IRQ_MASK) ||
                     (paddr == status_pkg::OFF_TX_BUFFER) ||
                     (paddr == status_pkg::OFF_RX_BUFFER);
    assign pslverr = psel && penable && !addr_ok;

    // Status word assembly; unimplemented bits read as zero.
    always_comb begin
        serial_bus_status = status_pkg::STATUS_RESET;
        serial_bus_status[status_pkg::BIT_ACK_RESULT] = slave_ack_result_reg;
        serial_bus_status[status_pkg::BIT_TX_PROGRESS] = master_tx_in_progress_reg;
        serial_bus_status[status_pkg::BIT_BUS_COLL] = bus_collision_flag_reg;
        serial_bus_status[status_pkg::BIT_GEN_CALL] = general_call_flag_reg;
        serial_bus_status[status_pkg::BIT_TEN_BIT] = ten_bit_addr_matched_reg;
        serial_bus_status[status_pkg::BIT_WR_COLL] = tx_write_collision_reg;
        serial_bus_status[status_pkg::BIT_RX_OVF] = rx_overflow_flag_reg;
        serial_bus_status[status_pkg::BIT_STOP_SEEN] = stop_flag_reg;
        serial_bus_status[status_pkg::BIT_START_SEEN] = start_flag_reg;
    end

    // Transmit in progress spans the byte and its acknowledge; start wins over end.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            master_tx_in_progress_reg <= 1'b0;
        end else if (tx_start) begin
            master_tx_in_progress_reg <= 1'b1;
        end else if (ack_end) begin
            master_tx_in_progress_reg <= 1'b0;
        end
    end

    // The acknowledge result is latched only at acknowledge end of a master transmit.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            slave_ack_result_reg <= 1'b0;
        end else if (ack_end && master_tx_in_progress_reg) begin
            slave_ack_result_reg <= ack_nack;
        end
    end

    // Collision flag is write-one-to-clear; a collision in the same cycle wins.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_collision_flag_reg <= 1'b0;
        end else if (collision_seen && master_op_active) begin
            bus_collision_flag_reg <= 1'b1;
        end else if (status_wr && pwdata[status_pkg::BIT_BUS_COLL]) begin
            bus_collision_flag_reg <= 1'b0;
        end
    end

    // Address flags live until stop; a match in the stop cycle is kept.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            general_call_flag_reg <= 1'b0;
        end else if (gen_call_match) begin
            general_call_flag_reg <= 1'b1;
        end else if (stop_seen) begin
            general_call_flag_reg <= 1'b0;
        end
    end

    // The ten-bit flag waits for the second address byte match.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ten_bit_addr_matched_reg <= 1'b0;
        end else if (ten_bit_second_match) begin
            ten_bit_addr_matched_reg <= 1'b1;
        end else if (stop_seen) begin
            ten_bit_addr_matched_reg <= 1'b0;
        end
    end

    // Write collision: only software clears it, and a new collision wins.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_write_collision_reg <= 1'b0;
        end else if (tx_wr && engine_busy) begin
            tx_write_collision_reg <= 1'b1;
        end else if (status_wr && pwdata[status_pkg::BIT_WR_COLL]) begin
            tx_write_collision_reg <= 1'b0;
        end
    end

    // Transmit buffer; writes while busy never reach the engine.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_data <= status_pkg::BUFFER_RESET;
            tx_load <= 1'b0;
        end else begin
            tx_load <= tx_wr && !engine_busy;
            if (tx_wr && !engine_busy) begin
                tx_data <= pwdata[7:0];
            end
        end
    end

    // Receive buffer; an overflowing byte is dropped so the unread one survives.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_buffer_reg <= status_pkg::BUFFER_RESET;
            rx_full_reg <= 1'b0;
        end else if (rx_byte_valid && !rx_full_reg) begin
            rx_buffer_reg <= rx_byte;
            rx_full_reg <= 1'b1;
        end else if (rx_rd) begin
            rx_full_reg <= 1'b0;
        end
    end

    // Overflow flag: software clears it, a new overflow in that cycle wins.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_overflow_flag_reg <= 1'b0;
        end else if (rx_byte_valid && rx_full_reg) begin
            rx_overflow_flag_reg <= 1'b1;
        end else if (status_wr && pwdata[status_pkg::BIT_RX_OVF]) begin
            rx_overflow_flag_reg <= 1'b0;
        end
    end

    // Last-condition flags; stop wins when start and stop arrive in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_flag_reg <= 1'b0;
            start_flag_reg <= 1'b0;
        end else if (stop_seen) begin
            stop_flag_reg <= 1'b1;
            start_flag_reg <= 1'b0;
        end else if (start_seen) begin
            stop_flag_reg <= 1'b0;
            start_flag_reg <= 1'b1;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_mask_reg <= status_pkg::IRQ_MASK_RESET;
        end else if (wr_access && (paddr == status_pkg::OFF_IRQ_MASK)) begin
            irq_mask_reg <= pwdata[3:0];
        end
    end

    // Interrupt events and clears.
    always_comb begin
        irq_event = '0;
        irq_event[status_pkg::IRQ_BUS_COLL] = collision_seen && master_op_active;
        irq_event[status_pkg::IRQ_WR_COLL] = tx_wr && engine_busy;
        irq_event[status_pkg::IRQ_RX_OVF] = rx_byte_valid && rx_full_reg;
        irq_event[status_pkg::IRQ_STOP] = stop_seen;
        irq_clear = '0;
        if (wr_access && (paddr == status_pkg::OFF_IRQ_STATUS)) begin
            irq_clear = pwdata[3:0];
        end
    end

    sticky_irq #(
        .WIDTH(status_pkg::IRQ_WIDTH)
    ) u_irq (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .event_pulse(irq_event),
        .clear_bits(irq_clear),
        .mask_bits(irq_mask_reg),
        .status_bits(irq_status),
        .irq(irq)
    );

    // Read mux; unmapped addresses return zero with an error.
    always_comb begin
        rdata_next = '0;
        case (paddr)
            status_pkg::OFF_STATUS: begin
                rdata_next = {16'h0000, serial_bus_status};
            end
            status_pkg::OFF_IRQ_STATUS: begin
                rdata_next = {28'h0000000, irq_status};
            end
            status_pkg::OFF_IRQ_MASK: begin
                rdata_next = {28'h0000000, irq_mask_reg};
            end
            status_pkg::OFF_TX_BUFFER: begin
                rdata_next = {24'h000000, tx_data};
            end
            status_pkg::OFF_RX_BUFFER: begin
                rdata_next = {24'h000000, rx_buffer_reg};
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Read data is combinational from registers, valid in the access cycle.
    assign prdata = rd_access ? rdata_next : 32'h00000000;

    property p_tx_set;
        @(posedge ref_clk) disable iff (!rst_b)
        tx_start |=> master_tx_in_progress_reg;
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("tx progress not set");

    property p_tx_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        (master_tx_in_progress_reg && !ack_end) |=> master_tx_in_progress_reg;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx progress dropped early");

    property p_coll;
        @(posedge ref_clk) disable iff (!rst_b)
        (collision_seen && master_op_active) |=> bus_collision_flag_reg;
    endproperty
    a_coll: assert property (p_coll) else $error("collision not flagged");

    property p_gc;
        @(posedge ref_clk) disable iff (!rst_b)
        (stop_seen && !gen_call_match) |=> !general_call_flag_reg;
    endproperty
    a_gc: assert property (p_gc) else $error("general call not cleared");

    sequence s_ten_match;
        ten_bit_second_match ##1 ten_bit_addr_matched_reg;
    endsequence
    property p_ten_set;
        @(posedge ref_clk) disable iff (!rst_b)
        ten_bit_second_match |-> s_ten_match;
    endproperty
    a_ten_set: assert property (p_ten_set) else $error("ten-bit flag not set");

    property p_ten_clr;
        @(posedge ref_clk) disable iff (!rst_b)
        (stop_seen && !ten_bit_second_match) |=> !ten_bit_addr_matched_reg;
    endproperty
    a_ten_clr: assert property (p_ten_clr) else $error("ten-bit flag not cleared");

    property p_ten;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(ten_bit_addr_matched_reg) |-> $past(ten_bit_second_match);
    endproperty
    a_ten: assert property (p_ten) else $error("ten-bit set without match");

    property p_wcol;
        @(posedge ref_clk) disable iff (!rst_b)
        (tx_wr && engine_busy) |=> (tx_write_collision_reg && !tx_load);
    endproperty
    a_wcol: assert property (p_wcol) else $error("busy write not refused");

    property p_ovf;
        @(posedge ref_clk) disable iff (!rst_b)
        (rx_byte_valid && rx_full_reg) |=> (rx_overflow_flag_reg && $stable(rx_buffer_reg));
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_stop;
        @(posedge ref_clk) disable iff (!rst_b)
        stop_seen |=> (stop_flag_reg && !start_flag_reg);
    endproperty
    a_stop: assert property (p_stop) else $error("stop flag not set");

    property p_ack;
        @(posedge ref_clk) disable iff (!rst_b)
        (ack_end && master_tx_in_progress_reg) |=> (slave_ack_result_reg == $past(ack_nack));
    endproperty
    a_ack: assert property (p_ack) else $error("ack result wrong");

    property p_start;
        @(posedge ref_clk) disable iff (!rst_b)
        (start_seen && !stop_seen) |=> !stop_flag_reg;
    endproperty
    a_start: assert property (p_start) else $error("stop flag not cleared");
endmodule // serial_status_flags

/* File: verif/engine_model.sv */
/*
  Bus engine stand-in: runs one master byte transmission per go request,
  one cycle per bit, then reports the slave acknowledge.
  Assumes the ref_clk and rst_b of the block under test.
*/
`timescale 1ns/1ps
module engine_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Requests from the bench.
    input wire logic go,
    input wire logic nack_in,
    // Engine events.
    output logic master_op_active,
    output logic engine_busy,
    output logic tx_start,
    output logic ack_end,
    output logic ack_nack
);
    logic [3:0] cnt_reg;

    // Eight data bits then the acknowledge bit, each one cycle long.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 4'h0;
            tx_start <= 1'b0;
            ack_end <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            ack_end <= 1'b0;
            if (go && cnt_reg == 4'h0) begin
                tx_start <= 1'b1;
                cnt_reg <= 4'h9;
            end else if (cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
                ack_end <= (cnt_reg == 4'h1);
            end
        end
    end

    // Busy covers the whole byte, acknowledge slot included.
    assign engine_busy = (cnt_reg != 4'h0) || ack_end;
    assign master_op_active = engine_busy;
    // Outside the acknowledge slot the level is inverted, so a stale sample shows.
    assign ack_nack = ack_end ? nack_in : ~nack_in;
endmodule // engine_model

/* File: verif/i2c_status_flag_logic_tb_top.sv */
/*
  Self-checking bench for the serial bus status flags.
  Assumes zero-wait APB answers and one-cycle event pulses.
*/
`timescale 1ns/1ps
module i2c_status_flag_logic_tb_top;
    logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, tx_load;
    logic go, nack;
    logic master_op_active, engine_busy, tx_start, ack_end, ack_nack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] sb;
    logic [7:0] tx_data, rx_byte, d1, d2;
    logic [5:0] ev;
    logic err;
    int n_errors, total_checks, n_load, cyc, hi;

    serial_status_flags u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .master_op_active(master_op_active), .engine_busy(engine_busy),
        .tx_start(tx_start), .ack_end(ack_end), .ack_nack(ack_nack),
        .collision_seen(ev[0]), .gen_call_match(ev[1]), .ten_bit_second_match(ev[2]),
        .start_seen(ev[3]), .stop_seen(ev[4]), .rx_byte_valid(ev[5]),
        .rx_byte(rx_byte), .tx_data(tx_data), .tx_load(tx_load),
        .serial_bus_status(sb), .irq(irq));

    engine_model u_eng (.ref_clk(ref_clk), .rst_b(rst_b), .go(go), .nack_in(nack),
        .master_op_active(master_op_active), .engine_busy(engine_busy),
        .tx_start(tx_start), .ack_end(ack_end), .ack_nack(ack_nack));

    // Free-running 50 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Count loads and cycles; a hang ends the run as a mismatch.
    always @(posedge ref_clk) begin
        if (tx_load === 1'b1) n_load++;
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // A byte occupies eight data bits plus the acknowledge bit.
    function automatic int tx_cycles();
        return 8 + 1;
    endfunction

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (e !== g) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bit_chk(int b, logic e);
        @(negedge ref_clk);
        chk($sformatf("status bit %0d", b), {31'h0, e}, {31'h0, sb[b]});
    endtask

    // One APB transfer; read data and error are taken where pready is sampled.
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(int i);
        @(posedge ref_clk);
        ev[i] <= 1'b1;
        @(posedge ref_clk);
        ev <= 6'h00;
    endtask

    task automatic start_tx(logic n);
        @(posedge ref_clk);
        go <= 1'b1;
        nack <= n;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        {rst_b, psel, penable, pwrite, go, nack} = 6'h00;
        {paddr, pwdata, ev, rx_byte} = '0;
        seed = 32'h0000f0a6;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        chk("status after reset", 32'h0, {16'h0, sb});
        chk("irq after reset", 32'h0, {31'h0, irq});
        // Random acknowledge results; progress flag must cover exactly one byte.
        for (int i = 0; i < 4; i++) begin
            d1 = 8'(xs());
            start_tx(d1[0]);
            hi = 0;
            repeat (14) begin
                @(negedge ref_clk);
                if (sb[status_pkg::BIT_TX_PROGRESS] === 1'b1) hi++;
            end
            chk("progress cycles", tx_cycles(), hi);
            bit_chk(status_pkg::BIT_ACK_RESULT, d1[0]);
        end
        // Collision and buffer write, both while the engine is busy.
        start_tx(1'b0);
        pulse(0);
        apb(1'b1, status_pkg::OFF_TX_BUFFER, 32'h5a);
        repeat (8) @(posedge ref_clk);
        bit_chk(status_pkg::BIT_BUS_COLL, 1'b1);
        bit_chk(status_pkg::BIT_WR_COLL, 1'b1);
        chk("discarded loads", 32'h0, n_load);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, status_pkg::OFF_IRQ_MASK, 32'h1);
        bit_chk(0, 1'b0);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        apb(1'b1, status_pkg::OFF_IRQ_STATUS, 32'hf);
        bit_chk(0, 1'b0);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Flags named by address, then stop: hardware leaves write collision set.
        pulse(1);
        bit_chk(status_pkg::BIT_GEN_CALL, 1'b1);
        pulse(2);
        bit_chk(status_pkg::BIT_TEN_BIT, 1'b1);
        pulse(3);
        bit_chk(status_pkg::BIT_START_SEEN, 1'b1);
        bit_chk(status_pkg::BIT_STOP_SEEN, 1'b0);
        pulse(4);
        bit_chk(status_pkg::BIT_GEN_CALL, 1'b0);
        bit_chk(status_pkg::BIT_TEN_BIT, 1'b0);
        bit_chk(status_pkg::BIT_STOP_SEEN, 1'b1);
        bit_chk(status_pkg::BIT_WR_COLL, 1'b1);
        apb(1'b1, status_pkg::OFF_STATUS, 32'h4c0);
        bit_chk(status_pkg::BIT_WR_COLL, 1'b0);
        bit_chk(status_pkg::BIT_BUS_COLL, 1'b0);
        // A collision outside a master operation leaves the flag clear.
        pulse(0);
        bit_chk(status_pkg::BIT_BUS_COLL, 1'b0);
        // Idle engine: the write is taken and handed on.
        d2 = 8'(xs());
        apb(1'b1, status_pkg::OFF_TX_BUFFER, {24'h0, d2});
        repeat (2) @(posedge ref_clk);
        chk("loads", 32'h1, n_load);
        chk("tx data", {24'h0, d2}, {24'h0, tx_data});
        // Second byte before the first is read overflows; the first survives.
        d1 = 8'(xs());
        rx_byte <= d1;
        pulse(5);
        bit_chk(status_pkg::BIT_RX_OVF, 1'b0);
        @(posedge ref_clk);
        rx_byte <= ~d1;
        pulse(5);
        bit_chk(status_pkg::BIT_RX_OVF, 1'b1);
        apb(1'b0, status_pkg::OFF_RX_BUFFER, 32'h0);
        chk("rx buffer", {24'h0, d1}, rd);
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        tally_and_finish();
    end
endmodule // i2c_status_flag_logic_tb_top
